//--- adcfg_regs.sv
`timescale 1ns/1ps
`default_nettype none

module adcfg_regs
    import adcfg_pkg::*;
#(
    parameter int CH = 8
)(
    input  wire logic            ref_clk,        // Device clock, 40 MHz
    input  wire logic            reset,          // Synchronous, active high
    input  wire logic [7:0]      reg_addr,       // Register offset
    input  wire logic [7:0]      reg_wdata,      // Write data
    input  wire logic            reg_write,      // Write strobe
    input  wire logic            reg_read,       // Read strobe
    output logic      [7:0]      reg_rdata,      // Read data, registered
    input  wire logic [CH*8-1:0] chan_volume,    // Per channel volume codes
    input  wire logic [ADCFG_ANALOG_CH-1:0] mic_digital, // Ch1-4 as PDM
    output logic      [CH*8-1:0] digital_volume, // Applied volume codes
    output logic      [1:0]      biquad_count,   // Biquads per channel
    output logic                 soft_step_en,   // Volume soft stepping
    output logic                 auto_gain_select,   // Gain controller on
    output logic      [3:0]      auto_gain_target,   // Target code
    output logic signed [7:0]    target_db,      // Target level in dB
    output logic      [3:0]      auto_gain_ceiling,  // Ceiling code
    output logic      [7:0]      ceiling_db,     // Ceiling in dB
    output logic                 ceiling_valid,  // Ceiling code legal
    output logic      [CH-1:0]   input_enable,   // Input channel enables
    output logic      [CH-1:0]   slot_data_en,   // Slot carries data
    output logic      [CH-1:0]   slot_oe_n,      // Slot driver enable, low
    output logic                 microphone_bias_on, // Bias generator on
    output logic                 synth_power_on, // PLL powered
    output logic      [1:0]      live_max_chan,  // Live mode channel span
    output logic      [ADCFG_ANALOG_CH-1:0] analog_power, // Analog chans
    output logic      [CH-1:0]   pdm_power,      // Digital mic chans
    output logic      [CH-1:0]   chan_power      // Channel powered
);

    logic [7:0]      dsp_q;
    logic [7:0]      gain_q;
    logic [7:0]      in_en_q;
    logic [7:0]      slot_q;
    logic [7:0]      pwr_q;
    logic [7:0]      rdata_q;
    logic [7:0]      rdata_d;
    logic [CH*8-1:0] vol_q;
    logic [CH-1:0]   state;
    logic            gang;

    // Write decode shared by all configuration registers
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------

    // Signal processing config; reserved low bits never stored
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            dsp_q <= ADCFG_RST_DSP_CFG_B;
        else if (reg_write && hit(reg_addr, ADCFG_OFS_DSP_CFG_B))
            dsp_q <= reg_wdata & ADCFG_MASK_DSP_CFG_B;
    end

    // Gain controller target and ceiling
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            gain_q <= ADCFG_RST_GAIN_CFG;
        else if (reg_write && hit(reg_addr, ADCFG_OFS_GAIN_CFG))
            gain_q <= reg_wdata;
    end

    // Input channel enables
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            in_en_q <= ADCFG_RST_IN_EN;
        else if (reg_write && hit(reg_addr, ADCFG_OFS_IN_EN))
            in_en_q <= reg_wdata;
    end

    // Serial slot enables; nothing drives until software asks
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            slot_q <= ADCFG_RST_SLOT_EN;
        else if (reg_write && hit(reg_addr, ADCFG_OFS_SLOT_EN))
            slot_q <= reg_wdata;
    end

    // Power config; reserved low bits never stored
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            pwr_q <= ADCFG_RST_POWER_UP_CONFIG;
        else if (reg_write && hit(reg_addr, ADCFG_OFS_POWER_UP_CONFIG))
            pwr_q <= reg_wdata & ADCFG_MASK_POWER_UP_CONFIG;
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------

    // Unmapped offsets read zero; status is a live snapshot
    always_comb
    begin
        rdata_d = 8'h00;
        unique case (reg_addr)
            ADCFG_OFS_DSP_CFG_B: rdata_d = dsp_q;
            ADCFG_OFS_GAIN_CFG:  rdata_d = gain_q;
            ADCFG_OFS_IN_EN:     rdata_d = in_en_q;
            ADCFG_OFS_SLOT_EN:   rdata_d = slot_q;
            ADCFG_OFS_POWER_UP_CONFIG:   rdata_d = pwr_q;
            ADCFG_OFS_PWR_STATE: rdata_d = state;
            default:             rdata_d = 8'h00;
        endcase
    end

    // Read data holds until the next read strobe
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            rdata_q <= 8'h00;
        else if (reg_read)
            rdata_q <= rdata_d;
    end

    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------
    // Signal processing controls
    // ------------------------------------------------------------

    assign gang = dsp_q[ADCFG_POS_GANG];

    // Channel one sits in the top byte; ganging ignores its own enable
    // so a muted-off channel one can still steer the others
    genvar g;
    generate
        for (g = 0; g < CH; g++)
        begin : g_vol
            always_ff @(posedge ref_clk)
            begin
                if (reset)
                    vol_q[g*8 +: 8] <= 8'h00;
                else if (gang)
                    vol_q[g*8 +: 8] <= chan_volume[(CH-1)*8 +: 8];
                else
                    vol_q[g*8 +: 8] <= chan_volume[g*8 +: 8];
            end
        end
    endgenerate

    assign digital_volume   = vol_q;
    assign biquad_count     = dsp_q[ADCFG_POS_BIQUAD +: 2];
    assign soft_step_en     = ~dsp_q[ADCFG_POS_SOFT_DIS];
    assign auto_gain_select = dsp_q[ADCFG_POS_AUTO_GAIN_SELECT];

    // Gain controller levels decoded to dB for the datapath
    assign auto_gain_target  = gain_q[ADCFG_POS_TARGET +: 4];
    assign target_db = ADCFG_TARGET_BASE_DB
        - $signed(8'(auto_gain_target) * ADCFG_TARGET_STEP_DB);
    assign auto_gain_ceiling = gain_q[ADCFG_POS_CEILING +: 4];
    assign ceiling_db = ADCFG_CEIL_BASE_DB
        + 8'(8'(auto_gain_ceiling) * ADCFG_CEIL_STEP_DB);
    assign ceiling_valid = (auto_gain_ceiling <= ADCFG_CEIL_LAST_CODE);

    // ------------------------------------------------------------
    // Enables and power
    // ------------------------------------------------------------

    assign input_enable = in_en_q;
    assign slot_data_en = slot_q;
    assign slot_oe_n    = ~slot_q;

    assign microphone_bias_on = pwr_q[ADCFG_POS_BIAS];
    assign synth_power_on     = pwr_q[ADCFG_POS_SYNTH];
    assign live_max_chan      = pwr_q[ADCFG_POS_MAXCH +: 2];

    // Per channel power follows enables under the converter power bit; while recording they are frozen unless the live bit is set
    adcfg_power_ctl #(
        .CH          (CH)
    ) u_power (
        .ref_clk     (ref_clk),
        .reset       (reset),
        .chan_enable (in_en_q),
        .conv_on     (pwr_q[ADCFG_POS_CONV]),
        .live_en     (pwr_q[ADCFG_POS_LIVE]),
        .power_state (state)
    );

    assign chan_power = state;

    // Upper channels have no analog path, so they are always PDM; the
    // lower four split by the mic_digital strap from the pin mux
    generate
        for (g = 0; g < CH; g++)
        begin : g_split
            if (g >= CH - ADCFG_ANALOG_CH)
            begin : g_dual
                // Channel one is the top bit of both status and strap
                assign analog_power[g-(CH-ADCFG_ANALOG_CH)] =
                    state[g] & ~mic_digital[g-(CH-ADCFG_ANALOG_CH)];
                assign pdm_power[g] =
                    state[g] & mic_digital[g-(CH-ADCFG_ANALOG_CH)];
            end
            else
            begin : g_pdm
                assign pdm_power[g] = state[g];
            end
        end
    endgenerate

endmodule

`default_nettype wire

//--- adcfg_pkg.sv
package adcfg_pkg;

    // Register offsets on the control port
    localparam logic [7:0] ADCFG_OFS_DSP_CFG_B   = 8'h6c;
    localparam logic [7:0] ADCFG_OFS_GAIN_CFG    = 8'h70;
    localparam logic [7:0] ADCFG_OFS_IN_EN       = 8'h73;
    localparam logic [7:0] ADCFG_OFS_SLOT_EN     = 8'h74;
    localparam logic [7:0] ADCFG_OFS_POWER_UP_CONFIG     = 8'h75;
    localparam logic [7:0] ADCFG_OFS_PWR_STATE   = 8'h76;

    // Reset values
    localparam logic [7:0] ADCFG_RST_DSP_CFG_B   = 8'h40;
    localparam logic [7:0] ADCFG_RST_GAIN_CFG    = 8'he7;
    localparam logic [7:0] ADCFG_RST_IN_EN       = 8'hf0;
    localparam logic [7:0] ADCFG_RST_SLOT_EN     = 8'h00;
    localparam logic [7:0] ADCFG_RST_POWER_UP_CONFIG     = 8'h00;

    // Writable bits; everything else is reserved and reads zero
    localparam logic [7:0] ADCFG_MASK_DSP_CFG_B  = 8'hf8;
    localparam logic [7:0] ADCFG_MASK_POWER_UP_CONFIG    = 8'hfc;

    // Field positions, signal processing config
    localparam int ADCFG_POS_GANG      = 7;
    localparam int ADCFG_POS_BIQUAD    = 5;
    localparam int ADCFG_POS_SOFT_DIS  = 4;
    localparam int ADCFG_POS_AUTO_GAIN_SELECT   = 3;
    // Field positions, gain control config
    localparam int ADCFG_POS_TARGET    = 4;
    localparam int ADCFG_POS_CEILING   = 0;
    // Field positions, power config
    localparam int ADCFG_POS_BIAS      = 7;
    localparam int ADCFG_POS_CONV      = 6;
    localparam int ADCFG_POS_SYNTH     = 5;
    localparam int ADCFG_POS_LIVE      = 4;
    localparam int ADCFG_POS_MAXCH     = 2;

    // Gain controller scaling in dB
    localparam logic signed [7:0] ADCFG_TARGET_BASE_DB  = 8'sh fa;
    localparam logic [7:0]        ADCFG_TARGET_STEP_DB  = 8'h02;
    localparam logic [7:0]        ADCFG_CEIL_BASE_DB    = 8'h03;
    localparam logic [7:0]        ADCFG_CEIL_STEP_DB    = 8'h03;
    localparam logic [3:0]        ADCFG_CEIL_LAST_CODE  = 4'hd;

    // Channels that may be analog converters
    localparam int ADCFG_ANALOG_CH = 4;

endpackage

//--- adcfg_power_ctl.sv
`timescale 1ns/1ps
`default_nettype none

module adcfg_power_ctl
    import adcfg_pkg::*;
#(
    parameter int CH = 8
)(
    input  wire logic          ref_clk,     // Device clock
    input  wire logic          reset,       // Synchronous, active high
    input  wire logic [CH-1:0] chan_enable, // Input enables, ch1 at msb
    input  wire logic          conv_on,     // Converter power bit
    input  wire logic          live_en,     // Live channel power enable
    output logic      [CH-1:0] power_state  // Channel powered up
);

    logic [CH-1:0] power_q;
    logic [CH-1:0] power_d;
    logic          recording;

    // Any channel powered counts as recording
    assign recording = |power_q;

    // Enables are frozen while recording unless live changes are allowed;
    // power off always wins so the whole group drops together
    always_comb
    begin
        power_d = power_q;
        if (!conv_on)
            power_d = '0;
        else if (live_en || !recording)
            power_d = chan_enable;
    end

    // Channel power state
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            power_q <= '0;
        else
            power_q <= power_d;
    end

    assign power_state = power_q;

endmodule

`default_nettype wire

//--- adcfg_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module adcfg_regs_monitor (
    input  wire logic              ref_clk,            // Device clock
    input  wire logic              reset,              // Sync, high
    input  wire logic [7:0]        reg_addr,           // Offset
    input  wire logic [7:0]        reg_wdata,          // Write data
    input  wire logic              reg_write,          // Write strobe
    input  wire logic              reg_read,           // Read strobe
    input  wire logic [7:0]        reg_rdata,          // Read data
    input  wire logic [3:0]        mic_digital,        // PDM select
    input  wire logic              soft_step_en,       // Soft stepping
    input  wire logic              auto_gain_select,   // Gain ctl on
    input  wire logic [3:0]        auto_gain_target,   // Target code
    input  wire logic signed [7:0] target_db,          // Target dB
    input  wire logic [3:0]        auto_gain_ceiling,  // Ceiling code
    input  wire logic [7:0]        ceiling_db,         // Ceiling dB
    input  wire logic              ceiling_valid,      // Code legal
    input  wire logic [7:0]        input_enable,       // Input enables
    input  wire logic [7:0]        slot_data_en,       // Slot enables
    input  wire logic [7:0]        slot_oe_n,          // Slot drive, low
    input  wire logic              microphone_bias_on, // Bias on
    input  wire logic              synth_power_on,     // PLL on
    input  wire logic [3:0]        analog_power,       // Analog chans
    input  wire logic [7:0]        pdm_power,          // PDM chans
    input  wire logic [7:0]        chan_power          // Channel up
);
    // ----------------------------------------
    // Port relations of the config registers
    // ----------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    // Converter bit cleared: status path lags the register by one cycle
    sequence pwr_clear;
        reg_write && reg_addr == 8'h75 && !reg_wdata[6];
    endsequence
    sequence chans_down;
        ##2 chan_power == 8'h00;
    endsequence

    conv_off_a: assert property (pwr_clear |-> chans_down)
        else $error("channels still powered");
    soft_step_a: assert property (reg_write && reg_addr == 8'h6c |=>
        soft_step_en != $past(reg_wdata[4])) else $error("soft step wrong");
    gain_sel_a: assert property (reg_write && reg_addr == 8'h6c |=>
        auto_gain_select == $past(reg_wdata[3])) else $error("gain select");
    target_map_a: assert property (
        target_db == 8'hfa - {3'h0, auto_gain_target, 1'b0})
        else $error("target level wrong");
    ceiling_map_a: assert property (ceiling_valid ==
        (auto_gain_ceiling <= 4'hd) && ceiling_db ==
        {4'h0, auto_gain_ceiling} * 8'h03 + 8'h03) else $error("ceiling");
    in_enable_a: assert property (reg_write && reg_addr == 8'h73 |=>
        input_enable == $past(reg_wdata)) else $error("input enable");
    pdm_split_a: assert property (
        analog_power == (chan_power[7:4] & ~mic_digital) && pdm_power ==
        {chan_power[7:4] & mic_digital, chan_power[3:0]})
        else $error("analog or pdm power wrong");
    slot_drive_a: assert property (reg_write && reg_addr == 8'h74 |=>
        slot_data_en == $past(reg_wdata) && slot_oe_n == ~$past(reg_wdata))
        else $error("slot enable wrong");
    bias_synth_a: assert property (reg_write && reg_addr == 8'h75 |=>
        microphone_bias_on == $past(reg_wdata[7]) &&
        synth_power_on == $past(reg_wdata[5])) else $error("bias or pll");
    status_read_a: assert property (reg_read && reg_addr == 8'h76 |=>
        reg_rdata == $past(chan_power)) else $error("status read wrong");
    unmapped_a: assert property (reg_read && reg_addr == 8'h00 |=>
        reg_rdata == 8'h00) else $error("unmapped read not zero");
endmodule

`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic              ref_clk = 1'b0;
    logic              reset = 1'b1;
    logic [7:0]        reg_addr = 8'h00;
    logic [7:0]        reg_wdata = 8'h00;
    logic              reg_write = 1'b0;
    logic              reg_read = 1'b0;
    logic [63:0]       chan_volume = 64'h0102030405060708;
    logic [3:0]        mic_digital = 4'ha;
    logic [63:0]       digital_volume;
    logic [7:0]        reg_rdata, ceiling_db, input_enable, chan_power;
    logic [7:0]        slot_data_en, slot_oe_n, pdm_power;
    logic [3:0]        auto_gain_target, auto_gain_ceiling, analog_power;
    logic [1:0]        biquad_count, live_max_chan;
    logic signed [7:0] target_db;
    logic              soft_step_en, auto_gain_select, ceiling_valid;
    logic              microphone_bias_on, synth_power_on;
    int                err_total = 0;
    int                tests_run = 0;
    int                cycles = 0;

    adcfg_regs adcfg_regs_i (.ref_clk, .reset, .reg_addr, .reg_wdata,
        .reg_write, .reg_read, .reg_rdata, .chan_volume, .mic_digital,
        .digital_volume, .biquad_count, .soft_step_en, .auto_gain_select,
        .auto_gain_target, .target_db, .auto_gain_ceiling, .ceiling_db,
        .ceiling_valid, .input_enable, .slot_data_en, .slot_oe_n,
        .microphone_bias_on, .synth_power_on, .live_max_chan,
        .analog_power, .pdm_power, .chan_power);

    // ----------------------------------------
    // Clock, hang guard and access tasks
    // ----------------------------------------
    always #12.5 ref_clk = ~ref_clk;

    // Run needs about two hundred cycles; the ceiling leaves wide margin
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string n, input logic [63:0] e, g);
        tests_run++;
        if (g !== e)
        begin
            err_total++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask

    // Extra edges let the channel power stage settle before looking
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        @(posedge ref_clk);
        chk("reg_rdata", 64'(e), 64'(reg_rdata));
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial
    begin
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        rd(8'h6c, 8'h40);
        rd(8'h70, 8'he7);
        rd(8'h73, 8'hf0);
        rd(8'h74, 8'h00);
        rd(8'h75, 8'h00);
        chk("slot_oe_n", 64'hff, 64'(slot_oe_n));
        $display("test reset_values done");
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h6c, {1'b0, i[1:0], 5'h1f});
            chk("biquad_count", 64'(i), 64'(biquad_count));
            rd(8'h6c, {1'b0, i[1:0], 5'h18});
        end
        for (int i = 0; i < 16; i++)
        begin
            wr(8'h70, {i[3:0], 4'(15 - i)});
            rd(8'h70, {i[3:0], 4'(15 - i)});
        end
        $display("test dsp_gain_fields done");
        wr(8'h6c, 8'h80);
        chk("digital_volume", {8{8'h01}}, digital_volume);
        wr(8'h6c, 8'h00);
        chk("digital_volume", chan_volume, digital_volume);
        wr(8'h74, 8'ha5);
        chk("slot_oe_n", 64'h5a, 64'(slot_oe_n));
        wr(8'h00, 8'hff);
        rd(8'h00, 8'h00);
        $display("test gang_slots done");
        wr(8'h75, 8'h40);
        rd(8'h76, 8'hf0);
        wr(8'h73, 8'hff);
        rd(8'h76, 8'hf0);
        wr(8'h76, 8'h00);
        wr(8'h75, 8'h5f);
        rd(8'h75, 8'h5c);
        chk("live_max_chan", 64'h3, 64'(live_max_chan));
        rd(8'h76, 8'hff);
        chk("analog_power", 64'h5, 64'(analog_power));
        chk("pdm_power", 64'haf, 64'(pdm_power));
        wr(8'h73, 8'he0);
        rd(8'h76, 8'he0);
        chk("analog_power", 64'h4, 64'(analog_power));
        chk("pdm_power", 64'ha0, 64'(pdm_power));
        wr(8'h75, 8'ha0);
        rd(8'h76, 8'h00);
        rd(8'h75, 8'ha0);
        $display("test power_control done");
        report_and_stop();
    end
endmodule

bind adcfg_regs adcfg_regs_monitor adcfg_regs_monitor_i (.ref_clk, .reset,
    .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .mic_digital,
    .soft_step_en, .auto_gain_select, .auto_gain_target, .target_db,
    .auto_gain_ceiling, .ceiling_db, .ceiling_valid, .input_enable,
    .slot_data_en, .slot_oe_n, .microphone_bias_on, .synth_power_on,
    .analog_power, .pdm_power, .chan_power);

`default_nettype wire
